// [logic/mcs_pkg.sv]
// Shared constants and carrier types for the memory copy sequencer
package mcs_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] REG_SRC_LO = 8'h00; // Source address, low word
  localparam logic [7:0] REG_SRC_HI = 8'h04; // Source address, high word
  localparam logic [7:0] REG_DST_LO = 8'h08; // Destination address, low word
  localparam logic [7:0] REG_DST_HI = 8'h0c; // Destination address, high word
  localparam logic [7:0] REG_CNT_LO = 8'h10; // Byte count, low word
  localparam logic [7:0] REG_CNT_HI = 8'h14; // Byte count, high word
  localparam logic [7:0] REG_FLAGS = 8'h18; // Condition flags n,z,c,v
  localparam logic [7:0] REG_CTRL = 8'h1c; // Algorithm and constraint choice
  localparam logic [7:0] REG_CMD = 8'h20; // Write issues one step
  localparam logic [7:0] REG_STATUS = 8'h24; // Busy and outcome of last step
  localparam logic [7:0] REG_PRO_BYTES = 8'h28; // Bytes copied by prologue
  localparam logic [7:0] REG_MAIN_BYTES = 8'h2c; // Bytes copied by main step

  // Flag bit positions inside the flags register
  localparam int FLG_N = 3; // Negative
  localparam int FLG_Z = 2; // Zero
  localparam int FLG_C = 1; // Carry
  localparam int FLG_V = 0; // Overflow

  // Control register bit positions
  localparam int CTRL_OPT_B = 0; // 1: option B algorithm
  localparam int CTRL_NOP_SEL = 1; // 1: bad register numbers run as no-op

  // Status register bit positions
  localparam int STS_BUSY = 0; // Step in progress
  localparam int STS_UNDEF = 1; // Last command was undefined
  localparam int STS_NOP = 2; // Last command ran as no-op
  localparam int STS_DONE = 3; // Last step completed

  // Stage, size and register field codes
  localparam logic [1:0] STG_PRO = 2'h0; // Prologue
  localparam logic [1:0] STG_MAIN = 2'h1; // Main
  localparam logic [1:0] STG_EPI = 2'h2; // Epilogue
  localparam logic [1:0] SIZE_OK = 2'h0; // Only legal size field
  localparam logic [4:0] REG_NUM_ZR = 5'h1f; // Register number 31

  // Flag patterns set by the prologue
  localparam logic [3:0] NZCV_OPT_A = 4'h0; // Option A, either direction
  localparam logic [3:0] NZCV_B_FWD = 4'h2; // Option B forward
  localparam logic [3:0] NZCV_B_BWD = 4'ha; // Option B backward

  // Count saturation limit and reset values
  localparam logic [63:0] SAT_MAX = 64'h007f_ffff_ffff_ffff; // Largest count kept
  localparam logic [31:0] PRO_BYTES_RST = 32'h0000_0004; // Prologue share
  localparam logic [31:0] MAIN_BYTES_RST = 32'h0000_0010; // Main share
  localparam logic [3:0] CTRL_RST = 4'h0; // Option A, undefined on bad regs

  // Command word layout, stage in the low bits
  typedef struct packed {
    logic [4:0] rn;    // Count register number
    logic [4:0] rd;    // Destination register number
    logic [4:0] rs;    // Source register number
    logic [1:0] size;  // Size field
    logic [1:0] stage; // Stage field
  } mcs_cmd_t;

  // Byte access toward the memory system
  typedef struct packed {
    logic req;         // Access pending
    logic we;          // 1 write, 0 read
    logic [63:0] addr; // Byte address
    logic [7:0] wdata; // Write byte
  } mcs_mem_req_t;

endpackage

// [logic/mcs_byte_mover.sv]
// One-byte read-then-write mover toward the memory system
`timescale 1ns/1ps
module mcs_byte_mover
  import mcs_pkg::*;
(
  input wire logic clk_i,               // System clock
  input wire logic rst_i,               // Synchronous reset, high
  input wire logic start_i,             // Pulse: move one byte
  input wire logic [63:0] rd_addr_i,    // Byte to read
  input wire logic [63:0] wr_addr_i,    // Byte to write
  output mcs_mem_req_t mem_o,           // Memory access
  input wire logic [7:0] mem_rdata_i,   // Read byte
  input wire logic mem_ack_i,           // Access complete
  output logic done_o                   // Pulse: byte written
);

  // One-hot mover states
  typedef enum logic [2:0] {
    MV_IDLE = 3'b001,
    MV_READ = 3'b010,
    MV_WRITE = 3'b100
  } mcs_mv_t;

  mcs_mv_t mv_q;         // Mover state
  mcs_mem_req_t mem_q;   // Registered request
  logic [63:0] wr_q;     // Destination held during read
  logic done_q;          // Completion pulse

  //////////////////////////////////////////////////////////////////////////
  // Read first, then write the same byte; request stands until ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mv_q <= MV_IDLE;
      mem_q <= '0;
      wr_q <= 64'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (mv_q)
        MV_IDLE: begin
          // Start ignored unless idle
          if (start_i) begin
            mem_q.req <= 1'b1;
            mem_q.we <= 1'b0;
            mem_q.addr <= rd_addr_i;
            wr_q <= wr_addr_i;
            mv_q <= MV_READ;
          end
        end
        MV_READ: begin
          // Turn straight into the write so the byte is never held long
          if (mem_ack_i) begin
            mem_q.we <= 1'b1;
            mem_q.addr <= wr_q;
            mem_q.wdata <= mem_rdata_i;
            mv_q <= MV_WRITE;
          end
        end
        MV_WRITE: begin
          if (mem_ack_i) begin
            mem_q.req <= 1'b0;
            mem_q.we <= 1'b0;
            done_q <= 1'b1;
            mv_q <= MV_IDLE;
          end
        end
      endcase
    end
  end

  assign mem_o = mem_q;
  assign done_o = done_q;

endmodule // mcs_byte_mover

// [logic/mcs_copy_engine.sv]
// Memory copy sequencer: prologue, main and epilogue steps behind Wishbone
// Functional notes
// - Prologue preconditions, prologue and main copy some
// - Source above destination with overlap: forward
// - Source not above, overlapping: backward
// - No overlap: direction is a free choice
// - Option A or B chosen by implementation
// - Option A prologue clears all four flags
// - Option A forward offsets addresses, negates count
// - Option A backward keeps addresses, count positive
// - Option B sets carry; forward advances addresses
// - Option B backward offsets addresses, sets negative
// - Option A main: negative count means forward
// - Option A main: positive count means backward
// - Option B main: negative clear means forward
// - Option B main: negative set means backward
// - Option A epilogue finishes, count ends zero
// - Option B forward epilogue ends count zero
// - Option B backward epilogue ends count zero
// - Stage 00 prologue, 01 main, 10 epilogue
// - Clashing or 31 register numbers: undefined or no-op
// - Feature absent or size nonzero: undefined
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module mcs_copy_engine
  import mcs_pkg::*;
#(
  parameter logic FEATURE_ON = 1'b1     // Copy feature present
) (
  input wire logic clk_i,               // System clock, 25 MHz
  input wire logic rst_i,               // Synchronous reset, high
  input wire logic wb_cyc_i,            // Wishbone cycle
  input wire logic wb_stb_i,            // Wishbone strobe
  input wire logic wb_we_i,             // Wishbone write enable
  input wire logic [7:0] wb_adr_i,      // Byte address
  input wire logic [3:0] wb_sel_i,      // Byte lanes
  input wire logic [31:0] wb_dat_i,     // Write data
  output logic [31:0] wb_dat_o,         // Read data
  output logic wb_ack_o,                // Acknowledge
  output mcs_mem_req_t mem_o,           // Byte access to memory
  input wire logic [7:0] mem_rdata_i,   // Read byte
  input wire logic mem_ack_i,           // Access complete
  output logic busy_o                   // Step in progress
);
  // One-hot engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PREP = 4'b0010,
    ST_MOVE = 4'b0100,
    ST_WAIT = 4'b1000
  } mcs_st_t;
  mcs_st_t st_q;                 // Engine state
  logic [63:0] src_q;            // source_addr_reg
  logic [63:0] dst_q;            // dest_addr_reg
  logic [63:0] cnt_q;            // byte_count_reg
  logic [3:0] nzcv_q;            // Condition flags
  logic opt_b_q;                 // Prologue algorithm choice
  logic nop_sel_q;               // Bad register numbers run as no-op
  logic [31:0] pro_bytes_q;      // Prologue share of the copy
  logic [31:0] main_bytes_q;     // Main share of the copy
  logic [1:0] stage_q;           // Stage being run
  logic [63:0] left_q;           // Bytes this step may still move
  logic run_a_q;                 // Step uses option A encoding
  logic fwd_q;                   // Step copies forward
  logic undef_q;                 // Last command undefined
  logic nop_q;                   // Last command was a no-op
  logic done_q;                  // Last step completed
  logic ack_q;                   // Bus acknowledge
  logic [31:0] rdat_q;           // Bus read data
  logic mv_start;                // Launch one byte move
  logic mv_done;                 // Byte move finished
  logic [63:0] rd_addr;          // Byte read address
  logic [63:0] wr_addr;          // Byte write address
  logic [63:0] sat;              // Saturated count
  logic [64:0] src_sum;          // Source plus saturated count
  logic [64:0] dst_sum;          // Destination plus saturated count
  logic ovl_fwd;                 // Overlap demanding forward
  logic ovl_bwd;                 // Overlap demanding backward
  logic pro_fwd;                 // Direction picked by prologue
  logic [63:0] rem;              // Bytes left in the whole copy
  logic bus_wr;                  // Write takes effect this edge
  logic bus_idle_wr;             // Write to state allowed
  mcs_cmd_t cmd;                 // Command word view
  logic bad_regs;                // Register numbers clash or are 31
  logic bad_cmd;                 // Command is undefined
  // Merge a write into a word under byte lanes
  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wdat,
                                          input logic [3:0] sel);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[8*i +: 8] = sel[i] ? wdat[8*i +: 8] : old[8*i +: 8];
    end
    return r;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // Prologue arithmetic
  // Saturate count first
  always_comb begin
    sat = (cnt_q > SAT_MAX) ? SAT_MAX : cnt_q;
    src_sum = {1'b0, src_q} + {1'b0, sat};
    dst_sum = {1'b0, dst_q} + {1'b0, sat};
  end
  assign ovl_fwd = (src_q > dst_q) && (dst_sum > {1'b0, src_q});
  assign ovl_bwd = (src_q <= dst_q) && (src_sum > {1'b0, dst_q});
  // No overlap goes forward; cheaper address stepping
  assign pro_fwd = ovl_fwd || !ovl_bwd;
  // Remaining total, sign depends on encoding
  assign rem = (run_a_q && fwd_q) ? (64'h0 - cnt_q) : cnt_q;
  //////////////////////////////////////////////////////////////////////////
  // Byte addresses per encoding and direction
  always_comb begin
    unique case ({run_a_q, fwd_q})
      // Lowest address is register plus negative count
      2'b11: begin
        rd_addr = src_q + cnt_q;
        wr_addr = dst_q + cnt_q;
      end
      // Highest address is register plus count minus one
      2'b10: begin
        rd_addr = src_q + cnt_q - 64'h1;
        wr_addr = dst_q + cnt_q - 64'h1;
      end
      // Registers hold the next lowest bytes
      2'b01: begin
        rd_addr = src_q;
        wr_addr = dst_q;
      end
      // Registers hold highest byte plus one
      default: begin
        rd_addr = src_q - 64'h1;
        wr_addr = dst_q - 64'h1;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////
  // Command decode
  assign cmd = mcs_cmd_t'(wb_dat_i[$bits(mcs_cmd_t)-1:0]);
  assign bad_regs = (cmd.rs == cmd.rn) || (cmd.rs == cmd.rd) || (cmd.rn == cmd.rd) ||
                    (cmd.rd == REG_NUM_ZR) || (cmd.rs == REG_NUM_ZR) || (cmd.rn == REG_NUM_ZR);
  // Missing feature, bad size, or unused stage code
  assign bad_cmd = !FEATURE_ON || (cmd.size != SIZE_OK) || (cmd.stage == 2'h3);
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign bus_idle_wr = bus_wr && (st_q == ST_IDLE);
  assign mv_start = (st_q == ST_MOVE) && (left_q != 64'h0) && (rem != 64'h0);
  //////////////////////////////////////////////////////////////////////////
  // Bus acknowledge and read data, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      // Unmapped offsets read as zero
      unique case (wb_adr_i)
        REG_SRC_LO: rdat_q <= src_q[31:0];
        REG_SRC_HI: rdat_q <= src_q[63:32];
        REG_DST_LO: rdat_q <= dst_q[31:0];
        REG_DST_HI: rdat_q <= dst_q[63:32];
        REG_CNT_LO: rdat_q <= cnt_q[31:0];
        REG_CNT_HI: rdat_q <= cnt_q[63:32];
        REG_FLAGS: rdat_q <= {28'h0, nzcv_q};
        REG_CTRL: rdat_q <= {30'h0, nop_sel_q, opt_b_q};
        REG_STATUS: rdat_q <= {28'h0, done_q, nop_q, undef_q, st_q != ST_IDLE};
        REG_PRO_BYTES: rdat_q <= pro_bytes_q;
        REG_MAIN_BYTES: rdat_q <= main_bytes_q;
        default: rdat_q <= 32'h0;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Configuration registers, writable at any time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {nop_sel_q, opt_b_q} <= CTRL_RST[1:0];
      pro_bytes_q <= PRO_BYTES_RST;
      main_bytes_q <= MAIN_BYTES_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        opt_b_q <= wb_dat_i[CTRL_OPT_B];
        nop_sel_q <= wb_dat_i[CTRL_NOP_SEL];
      end
      if (wb_adr_i == REG_PRO_BYTES) begin
        pro_bytes_q <= merge32(pro_bytes_q, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == REG_MAIN_BYTES) begin
        main_bytes_q <= merge32(main_bytes_q, wb_dat_i, wb_sel_i);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Copy state and sequencing; bus writes to state only land while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      src_q <= 64'h0;
      dst_q <= 64'h0;
      cnt_q <= 64'h0;
      nzcv_q <= 4'h0;
      stage_q <= STG_PRO;
      left_q <= 64'h0;
      run_a_q <= 1'b1;
      fwd_q <= 1'b1;
      undef_q <= 1'b0;
      nop_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (bus_idle_wr) begin
            unique case (wb_adr_i)
              REG_SRC_LO: src_q[31:0] <= merge32(src_q[31:0], wb_dat_i, wb_sel_i);
              REG_SRC_HI: src_q[63:32] <= merge32(src_q[63:32], wb_dat_i, wb_sel_i);
              REG_DST_LO: dst_q[31:0] <= merge32(dst_q[31:0], wb_dat_i, wb_sel_i);
              REG_DST_HI: dst_q[63:32] <= merge32(dst_q[63:32], wb_dat_i, wb_sel_i);
              REG_CNT_LO: cnt_q[31:0] <= merge32(cnt_q[31:0], wb_dat_i, wb_sel_i);
              REG_CNT_HI: cnt_q[63:32] <= merge32(cnt_q[63:32], wb_dat_i, wb_sel_i);
              REG_FLAGS: nzcv_q <= wb_sel_i[0] ? wb_dat_i[3:0] : nzcv_q; // Lane 0 only
              REG_CMD: begin
                // Order is software's; each command with legal fields and registers runs as issued
                undef_q <= bad_cmd || (bad_regs && !nop_sel_q);
                nop_q <= !bad_cmd && bad_regs && nop_sel_q;
                done_q <= 1'b0;
                stage_q <= cmd.stage;
                if (!bad_cmd && !bad_regs) begin
                  st_q <= ST_PREP;
                end
              end
              default: ; // Control and share offsets live in the config process; status and unmapped writes are dropped
            endcase
          end
        end
        ST_PREP: begin
          st_q <= ST_MOVE;
          unique case (stage_q)
            STG_PRO: begin
              left_q <= {32'h0, pro_bytes_q};
              fwd_q <= pro_fwd;
              run_a_q <= !opt_b_q;
              if (!opt_b_q) begin
                nzcv_q <= NZCV_OPT_A;
                if (pro_fwd) begin
                  src_q <= src_q + sat;
                  dst_q <= dst_q + sat;
                  cnt_q <= 64'h0 - sat;
                end else begin
                  cnt_q <= sat;
                end
              end else begin
                cnt_q <= sat;
                if (pro_fwd) begin
                  nzcv_q <= NZCV_B_FWD;
                end else begin
                  src_q <= src_q + sat;
                  dst_q <= dst_q + sat;
                  nzcv_q <= NZCV_B_BWD;
                end
              end
            end
            STG_MAIN: begin
              left_q <= {32'h0, main_bytes_q};
              run_a_q <= !nzcv_q[FLG_C];
              fwd_q <= nzcv_q[FLG_C] ? !nzcv_q[FLG_N] : cnt_q[63];
            end
            default: begin
              left_q <= 64'hffff_ffff_ffff_ffff;
              run_a_q <= !nzcv_q[FLG_C];
              fwd_q <= nzcv_q[FLG_C] ? !nzcv_q[FLG_N] : cnt_q[63];
            end
          endcase
        end
        ST_MOVE: begin
          if (mv_start) begin
            st_q <= ST_WAIT;
          end else begin
            st_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (mv_done) begin
            st_q <= ST_MOVE;
            left_q <= left_q - 64'h1;
            unique case ({run_a_q, fwd_q})
              2'b11: cnt_q <= cnt_q + 64'h1;
              2'b10: cnt_q <= cnt_q - 64'h1;
              2'b01: begin
                src_q <= src_q + 64'h1;
                dst_q <= dst_q + 64'h1;
                cnt_q <= cnt_q - 64'h1;
              end
              // Highest uncopied plus one written back
              default: begin
                src_q <= src_q - 64'h1;
                dst_q <= dst_q - 64'h1;
                cnt_q <= cnt_q - 64'h1;
              end
            endcase
          end
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Byte mover toward the memory system
  mcs_byte_mover u_mover (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(mv_start),
    .rd_addr_i(rd_addr),
    .wr_addr_i(wr_addr),
    .mem_o(mem_o),
    .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i),
    .done_o(mv_done)
  );
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign busy_o = (st_q != ST_IDLE);
endmodule // mcs_copy_engine

// [tb/mcs_copy_engine_asserts.sv]
// Port-level concurrent checks for the copy engine
`timescale 1ns/1ps
module mcs_copy_engine_asserts
  import mcs_pkg::*;
(
  input wire logic clk_i,             // Clock
  input wire logic rst_i,             // Reset
  input wire logic wb_cyc_i,          // Cycle
  input wire logic wb_stb_i,          // Strobe
  input wire logic wb_we_i,           // Write
  input wire logic [7:0] wb_adr_i,    // Address
  input wire logic [31:0] wb_dat_o,   // Read data
  input wire logic wb_ack_o,          // Ack
  input mcs_mem_req_t mem_o,          // Memory request
  input wire logic [7:0] mem_rdata_i, // Read byte
  input wire logic mem_ack_i,         // Memory ack
  input wire logic busy_o             // Busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_cmd_reads_zero: assert property (wb_ack_o && !$past(wb_we_i) &&
    ($past(wb_adr_i) == REG_CMD || $past(wb_adr_i) == 8'h40) |-> wb_dat_o == 32'h0)
    else $error("write-only or unmapped read not zero");
  a_mem_hold: assert property (mem_o.req && !mem_ack_i |=> $stable(mem_o))
    else $error("memory request changed before ack");
  a_read_first: assert property ($rose(mem_o.req) |-> !mem_o.we)
    else $error("byte move did not start with a read");
  a_read_then_write: assert property (mem_o.req && !mem_o.we && mem_ack_i |=>
    mem_o.req && mem_o.we && mem_o.wdata == $past(mem_rdata_i))
    else $error("write does not carry the byte read");
  a_write_gap: assert property (mem_o.req && mem_o.we && mem_ack_i |=> !mem_o.req [*2])
    else $error("next byte started too soon");
  a_idle_quiet: assert property (!busy_o |-> !mem_o.req)
    else $error("memory access while idle");
endmodule // mcs_copy_engine_asserts

bind mcs_copy_engine mcs_copy_engine_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
  .mem_ack_i(mem_ack_i), .busy_o(busy_o));

// [tb/mcs_mem_model.sv]
// Byte-wide memory system model facing the copy engine
`timescale 1ns/1ps
module mcs_mem_model
  import mcs_pkg::*;
(
  input wire logic clk_i,    // Clock
  input wire logic rst_i,    // Reset
  input mcs_mem_req_t mem_i, // Request
  input wire logic slow_i,   // Stall each access
  output logic [7:0] rdata_o, // Read byte
  output logic ack_o         // Completion pulse
);
  logic [7:0] mem [logic [63:0]]; // Written bytes only
  int wait_q;                     // Stall counter
  // Untouched bytes read a fixed address pattern
  function automatic logic [7:0] rd(input logic [63:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
  endfunction
  // One ack per access; data toggles when not acked so stale bytes show
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= rst_i ? 8'h00 : ~rdata_o;
    if (rst_i || ack_o || !mem_i.req) begin
      wait_q <= 0;
    end else if (wait_q < (slow_i ? 3 : 0)) begin
      wait_q <= wait_q + 1;
    end else begin
      ack_o <= 1'b1;
      rdata_o <= rd(mem_i.addr);
      if (mem_i.we) begin
        mem[mem_i.addr] = mem_i.wdata;
      end
    end
  end
endmodule // mcs_mem_model

// [tb/mcs_copy_engine_tb.sv]
// Self-checking bench for the copy engine
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module mcs_copy_engine_tb;
  import mcs_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0; // Bench drives
  logic [7:0] adr = '0;   // Bus address
  logic [31:0] wdat = '0; // Bus write data
  logic [3:0] sel = '0;   // Byte lanes
  logic [31:0] dat_o, q;  // Read data, last taken
  logic ack, busy, mack;  // Handshakes
  logic [7:0] mrd;        // Memory read byte
  mcs_mem_req_t mreq;     // Memory request
  logic [63:0] s0, d0, n, c, off; // Reference model state
  logic fwd, optb;        // Reference direction and option
  int fails = 0, num_checks = 0, seed = 78;
  always #20 clk_i = ~clk_i;
  mcs_copy_engine uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .mem_o(mreq), .mem_rdata_i(mrd), .mem_ack_i(mack), .busy_o(busy));
  mcs_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mreq), .slow_i(slow),
    .rdata_o(mrd), .ack_o(mack));
  ////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Classic single cycle; held until ack seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (t >= 20) fails++;
  endtask
  task automatic rd64(input logic [7:0] a, output logic [63:0] v);
    wb(0, a, 0);
    v[31:0] = q;
    wb(0, a + 8'h4, 0);
    v[63:32] = q;
  endtask
  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    wb(1, a, v[31:0]);
    wb(1, a + 8'h4, v[63:32]);
  endtask
  // Status polled until the step is over; bounded
  task automatic poll;
    int t = 0;
    do begin wb(0, REG_STATUS, 0); t++; end while (q[STS_BUSY] !== 1'b0 && t < 300);
    if (t >= 300) fails++;
  endtask
  // Issue one step and compare registers with the reference
  task automatic step(input logic [1:0] stg);
    mcs_cmd_t cmd;
    logic [63:0] v, share;
    cmd = '{rn: 5'd3, rd: 5'd2, rs: 5'd1, size: SIZE_OK, stage: stg};
    wb(1, REG_CMD, 32'(cmd));
    poll();
    `CHK(q[STS_DONE], 1'b1)
    `CHK(busy, 1'b0)
    share = (stg == STG_PRO) ? 64'd2 : (stg == STG_MAIN) ? 64'd3 : n - c;
    c = c + ((n - c < share) ? n - c : share);
    off = !optb ? (fwd ? n : 64'h0) : (fwd ? c : n - c);
    rd64(REG_CNT_LO, v);
    `CHK(v, (!optb && fwd) ? c - n : n - c)
    if (!(stg == STG_EPI && !optb && fwd)) begin
      rd64(REG_SRC_LO, v);
      `CHK(v, s0 + off)
      rd64(REG_DST_LO, v);
      `CHK(v, d0 + off)
    end
    wb(0, REG_FLAGS, 0);
    `CHK(q[3:0], !optb ? NZCV_OPT_A : fwd ? NZCV_B_FWD : NZCV_B_BWD)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    static logic [7:0] ra [5] = '{REG_PRO_BYTES, REG_MAIN_BYTES, REG_CTRL, REG_CMD, 8'h40};
    static logic [31:0] rv [5] = '{32'h4, 32'h10, 32'h0, 32'h0, 32'h0};
    logic [7:0] expq [$];
    logic [63:0] nreq;
    logic [31:0] keep;
    mcs_cmd_t cmd;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values; unmapped write must vanish
    wb(1, 8'h40, 32'hffff_ffff);
    foreach (ra[k]) begin wb(0, ra[k], 0); `CHK(q, rv[k]) end
    wb(1, REG_PRO_BYTES, 32'h2);
    wb(1, REG_MAIN_BYTES, 32'h3);
    // Both options, each direction, disjoint, then one saturating count
    for (int i = 0; i < 7; i++) begin
      optb = (i == 6) || i[0];
      s0 = {32'h0, 32'($random(seed))} | 64'h1000;
      d0 = (i < 2) ? s0 - 3 : (i < 4) ? s0 + 3 : s0 + 64'h100;
      nreq = (i == 6) ? '1 : 64'(5 + ($random(seed) & 7));
      slow <= 1'($random(seed));
      n = (nreq > SAT_MAX) ? SAT_MAX : nreq;
      fwd = !(s0 <= d0 && s0 + n > d0);
      c = 0;
      expq.delete();
      for (int k = 0; k < 16; k++) expq.push_back(u_mem.rd(s0 + 64'(k)));
      wr64(REG_SRC_LO, s0);
      wr64(REG_DST_LO, d0);
      wr64(REG_CNT_LO, nreq);
      wb(1, REG_CTRL, {31'h0, optb});
      step(STG_PRO);
      if (i < 6) begin
        step(STG_MAIN);
        step(STG_EPI);
        for (int k = 0; k < n; k++) `CHK(u_mem.rd(d0 + 64'(k)), expq[k])
      end
      $display("copy case %0d done", i);
    end
    // Bad size, bad stage, clashing regs, register 31 as no-op
    for (int k = 0; k < 4; k++) begin
      cmd = '{rn: 5'd3, rd: 5'd2, rs: 5'd1, size: SIZE_OK, stage: STG_MAIN};
      if (k == 0) cmd.size = 2'h1;
      if (k == 1) cmd.stage = 2'h3;
      if (k == 2) cmd.rd = 5'd1;
      if (k == 3) cmd.rn = REG_NUM_ZR;
      wb(1, REG_CTRL, {30'h0, k == 3, 1'b0});
      wb(0, REG_CNT_LO, 0);
      keep = q;
      wb(1, REG_CMD, 32'(cmd));
      poll();
      `CHK(q[STS_UNDEF], 1'(k != 3))
      `CHK(q[STS_NOP], 1'(k == 3))
      `CHK(q[STS_DONE], 1'b0)
      wb(0, REG_CNT_LO, 0);
      `CHK(q, keep)
      $display("refused command %0d done", k);
    end
    final_report();
  end
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    fails++;
    final_report();
  end
endmodule // mcs_copy_engine_tb
